// [hdl/sbcc_pkg.sv]
package sbcc_pkg;

  // ---------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SAMPLE_MS      = 125;
  localparam int unsigned BCAST_S        = 10;
  localparam int unsigned SAMPLE_CYC     = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned BCAST_SAMPLES  = BCAST_S * 1000 / SAMPLE_MS;

  // ---------------------------------------------------------------
  // field layout and constants
  // ---------------------------------------------------------------
  localparam int unsigned NCELL          = 4;
  localparam int unsigned HOST_LO_BIT    = 8;
  localparam int unsigned CHG_LO_BIT     = 12;
  localparam int unsigned BCAST_DIS_BIT  = 2;
  localparam logic [15:0] FAST_HYST_DK   = 16'h001e;  // 3 degC in 0.1 units
  localparam logic [15:0] PC_TEMP_MAX    = 16'h007f;  // 12.7 degC
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [7:0]  ONE8           = 8'h01;

  typedef enum logic [1:0] {
    SBCC_CUR_ZERO, SBCC_CUR_PRE, SBCC_CUR_MAINT, SBCC_CUR_FAST
  } sbcc_rate_t;

  typedef enum logic [1:0] {
    SBCC_MSG_CHG_CUR, SBCC_MSG_CHG_VOLT, SBCC_MSG_ALARM
  } sbcc_msg_t;

  typedef enum logic {SBCC_ADDR_HOST, SBCC_ADDR_CHARGER} sbcc_dest_t;

  // configuration constants in mV, mA, 0.1 degC or 125 ms units, plus flags
  typedef struct packed {
    logic [15:0] chg_volt;
    logic [15:0] ov_margin;
    logic [15:0] cell_ov;
    logic [15:0] fast_cur;
    logic [15:0] maint_cur;
    logic [15:0] pre_cur;
    logic [15:0] pre_volt;
    logic [15:0] pre_temp;
    logic [15:0] inhibit_low;
    logic [15:0] susp_low;
    logic [15:0] susp_high;
    logic [15:0] susp_high_rst;
    logic [15:0] oc_thresh;
    logic [7:0]  oc_time;
    logic [15:0] clear_fail_cur;
    logic [7:0]  fault_rst_time;
    logic [15:0] max_chg_time;
    logic [15:0] v_on;
    logic [15:0] v_off;
    logic [15:0] v_max;
    logic [7:0]  min_off;
    logic [7:0]  max_on;
    logic [7:0]  pack_cfg;
    logic        nonremovable;
    logic        overtemp_fet_action_enable;
  } sbcc_cfg_t;

  // measurement front end
  typedef struct packed {
    logic [15:0] pack_volt;
    logic [15:0] cell_max;
    logic [15:0] temp;
    logic [15:0] chg_cur;
    logic [15:0] avg_cur;
    logic        discharging;
    logic        pack_removed;
    logic        end_of_discharge_level;
    logic        terminate;
    logic        cell_low;
  } sbcc_meas_t;

  typedef struct packed {
    sbcc_msg_t   kind;
    sbcc_dest_t  dest;
    logic [15:0] data;
  } sbcc_msg_word_t;

endpackage : sbcc_pkg

// [hdl/sbcc_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
module sbcc_timebase
  import sbcc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned BCAST_TICKS   = BCAST_SAMPLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick_125,
  output logic      tick_10s
);
  logic [31:0] cyc_q;
  logic [7:0]  smp_q;
  wire         cyc_wrap = (cyc_q == 32'(SAMPLE_CYCLES - 1));
  wire         smp_wrap = (smp_q == 8'(BCAST_TICKS - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
      smp_q <= '0;
    end else begin
      cyc_q <= cyc_wrap ? '0 : cyc_q + 32'h1;
      if (cyc_wrap) smp_q <= smp_wrap ? '0 : smp_q + 8'h01;
    end
  end

  assign tick_125 = cyc_wrap;
  assign tick_10s = cyc_wrap && smp_wrap;
endmodule : sbcc_timebase
`default_nettype wire

// [hdl/sbcc_pulse.sv]
`timescale 1ns/1ps
`default_nettype none
module sbcc_pulse
  import sbcc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        charging,
  input  wire logic        fault,
  input  wire logic [15:0] volt,
  input  wire logic [15:0] v_on,
  input  wire logic [15:0] v_off,
  input  wire logic [15:0] v_max,
  input  wire logic [7:0]  min_off,
  input  wire logic [7:0]  max_on,
  output logic             fet_on
);
  logic       on_q;
  logic [7:0] on_cnt_q;
  logic [7:0] off_cnt_q;

  wire over_max  = volt > v_max;
  wire over_off  = volt > v_off;
  wire below_on  = volt < v_on;
  wire on_expire = (on_cnt_q == 8'h00);
  wire off_met   = (off_cnt_q >= min_off) || (min_off <= ONE8);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      on_q      <= 1'b0;
      on_cnt_q  <= 8'h00;
      off_cnt_q <= 8'h00;
    end else if (fault || !charging) begin
      on_q      <= 1'b0;
      off_cnt_q <= 8'h00;
    end else if (tick) begin
      if (on_q) begin
        if (over_max || (over_off && on_expire)) begin
          on_q      <= 1'b0;
          off_cnt_q <= 8'h01;
        end else if (over_off && !on_expire) begin
          on_cnt_q <= on_cnt_q - 8'h01;
        end
      end else if (below_on && off_met) begin
        on_q     <= 1'b1;
        on_cnt_q <= max_on;
      end else if (off_cnt_q != 8'hff) begin
        off_cnt_q <= off_cnt_q + 8'h01;
      end
    end
  end

  assign fet_on = on_q;
endmodule : sbcc_pulse
`default_nettype wire

// [hdl/sbcc_charge_ctrl.sv]
// Notes on behaviour
// - charging current and voltage sent to charger every 10 s
// - charging voltage is a 16-bit mV constant, base of the pack OV check
// - current request is fast, maintenance, precharge or zero
// - termination gives zero; maintenance only after termination clears
// - precharge set on low cell or end of discharge, cleared at the first sample with both low
// - precharge in cold band; fast needs threshold plus 3 degC
// - precharge temperature threshold in 0.1 degC, at most 12.7
// - status bits 8-15 send alarm to host
// - status bits 12-15 also send alarm to charger
// - alarms repeat every 10 s while bits stay set
// - broadcast disable bit 2 suppresses all broadcasts
// - overcurrent beyond time drops charge FET, discharge FET if removable
// - OC/OV clear on removal, or discharge/low average if nonremovable
// - overtemperature with action enabled drops both FETs until at or below suspend-high reset, or removal
// - undertemperature drops charge FET until above suspend-low
// - max charge time drops charge FET until discharge or removal
// - cell or pack overvoltage flags fault and suspends charge
// - cell voltages sampled each 125 ms, highest cell used
// - FET on: off on max, or off-threshold with on time expired
// - FET off: on below on-threshold once min off met
// - times in 125 ms units; min off 0 or 1 disables limit
// - any fault overrides pulse control and stops charge
`timescale 1ns/1ps
`default_nettype none
module sbcc_charge_ctrl
  import sbcc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned BCAST_TICKS   = BCAST_SAMPLES
) (
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  input  wire sbcc_cfg_t      cfg,
  input  wire sbcc_meas_t     meas,
  input  wire logic [15:0]    batt_status,
  input  wire logic           msg_ready,
  output logic                msg_valid,
  output sbcc_msg_word_t      msg,
  output logic [15:0]         chg_cur_req,
  output logic [15:0]         chg_volt_req,
  output sbcc_rate_t          rate,
  output logic                chg_fet_on,
  output logic                dsg_fet_on,
  output logic [4:0]          fault_flags
);

  // ---------------------------------------------------------------
  // reset release and timebase
  // ---------------------------------------------------------------
  logic rst_s1_q, rst_n;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  logic tick_125, tick_10s;
  sbcc_timebase #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .BCAST_TICKS   (BCAST_TICKS)
  ) u_tb (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tick_125 (tick_125),
    .tick_10s (tick_10s)
  );

  // ---------------------------------------------------------------
  // temperature and voltage decode
  // ---------------------------------------------------------------
  wire [15:0] pc_temp  = (cfg.pre_temp > PC_TEMP_MAX) ? PC_TEMP_MAX
                                                      : cfg.pre_temp;
  wire [16:0] fast_t   = {1'b0, pc_temp} + {1'b0, FAST_HYST_DK};
  wire        cold_pre = (meas.temp >= cfg.inhibit_low) &&
                         (meas.temp < pc_temp);
  wire        fast_ok_t = {1'b0, meas.temp} >= fast_t;
  wire        charging  = chg_fet_on && !meas.discharging;
  wire [16:0] ov_lim   = {1'b0, cfg.chg_volt} + {1'b0, cfg.ov_margin};
  wire        ov_now   = (meas.cell_max > cfg.cell_ov) ||
                         ({1'b0, meas.pack_volt} > ov_lim);
  wire        oc_now   = meas.chg_cur > cfg.oc_thresh;
  wire        hot_now  = charging && (meas.temp > cfg.susp_high);
  wire        cold_now = charging && ((meas.temp < cfg.susp_low) ||
                         (meas.temp < cfg.inhibit_low));
  wire        low_avg  = meas.avg_cur < cfg.clear_fail_cur;
  wire        nr_clr   = cfg.nonremovable && meas.discharging;

  // ---------------------------------------------------------------
  // fault latches, evaluated per sample
  // ---------------------------------------------------------------
  logic        oc_q, ov_q, ot_q, ut_q, tm_q, pre_q;
  logic [7:0]  oc_cnt_q, frt_cnt_q;
  logic [15:0] chg_time_q;

  wire oc_clr  = meas.pack_removed || nr_clr ||
                 (cfg.nonremovable && low_avg &&
                  frt_cnt_q >= cfg.fault_rst_time);
  wire tm_hit  = chg_time_q >= cfg.max_chg_time;
  wire pre_set = meas.cell_low || meas.end_of_discharge_level;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_q       <= 1'b0;
      ov_q       <= 1'b0;
      ot_q       <= 1'b0;
      ut_q       <= 1'b0;
      tm_q       <= 1'b0;
      pre_q      <= 1'b0;
      oc_cnt_q   <= 8'h00;
      frt_cnt_q  <= 8'h00;
      chg_time_q <= ZERO16;
    end else if (tick_125) begin
      oc_cnt_q <= oc_now ? ((oc_cnt_q == 8'hff) ? oc_cnt_q
                            : oc_cnt_q + 8'h01) : 8'h00;
      frt_cnt_q <= (low_avg && (oc_q || ov_q)) ?
                   ((frt_cnt_q == 8'hff) ? frt_cnt_q : frt_cnt_q + 8'h01)
                   : 8'h00;
      // sets win over clears, except the charge-time fault
      if (oc_now && oc_cnt_q >= cfg.oc_time) oc_q <= 1'b1;
      else if (oc_clr) oc_q <= 1'b0;
      if (ov_now) ov_q <= 1'b1;
      else if (oc_clr) ov_q <= 1'b0;
      if (hot_now && cfg.overtemp_fet_action_enable) ot_q <= 1'b1;
      else if (meas.temp <= cfg.susp_high_rst || meas.pack_removed)
        ot_q <= 1'b0;
      if (cold_now) ut_q <= 1'b1;
      else if (meas.temp > cfg.susp_low || meas.pack_removed)
        ut_q <= 1'b0;
      if (meas.discharging || meas.pack_removed) begin
        chg_time_q <= ZERO16;
        tm_q       <= 1'b0;
      end else begin
        if (charging && !tm_hit) chg_time_q <= chg_time_q + 16'h0001;
        if (tm_hit) tm_q <= 1'b1;
      end
      if (pre_set) pre_q <= 1'b1;
      else if (!meas.cell_low && !meas.end_of_discharge_level)
        pre_q <= 1'b0;
    end
  end

  wire any_fault = oc_q || ov_q || ot_q || ut_q || tm_q;

  // ---------------------------------------------------------------
  // pulse charge and FETs
  // ---------------------------------------------------------------
  logic pulse_on;
  sbcc_pulse u_pulse (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tick     (tick_125),
    .charging (!meas.discharging),
    .fault    (any_fault),
    .volt     (meas.cell_max),
    .v_on     (cfg.v_on),
    .v_off    (cfg.v_off),
    .v_max    (cfg.v_max),
    .min_off  (cfg.min_off),
    .max_on   (cfg.max_on),
    .fet_on   (pulse_on)
  );

  // charge FET on while discharging keeps IR loss low; faults win
  wire chg_fet_d = !any_fault && (pulse_on || meas.discharging);
  wire dsg_fet_d = !ot_q && !(oc_q && !cfg.nonremovable);

  logic chg_fet_q, dsg_fet_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chg_fet_q <= 1'b0;
      dsg_fet_q <= 1'b0;
    end else begin
      chg_fet_q <= chg_fet_d;
      dsg_fet_q <= dsg_fet_d;
    end
  end
  assign chg_fet_on  = chg_fet_q;
  assign dsg_fet_on  = dsg_fet_q;
  assign fault_flags = {tm_q, ut_q, ot_q, ov_q, oc_q};

  // ---------------------------------------------------------------
  // current request selection
  // ---------------------------------------------------------------
  logic       term_seen_q;
  sbcc_rate_t rate_d, rate_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) term_seen_q <= 1'b0;
    else if (meas.terminate) term_seen_q <= 1'b1;
    else if (meas.discharging || meas.pack_removed) term_seen_q <= 1'b0;
  end

  always_comb begin
    if (any_fault || meas.terminate)      rate_d = SBCC_CUR_ZERO;
    else if (pre_q || cold_pre || !fast_ok_t)
                                          rate_d = SBCC_CUR_PRE;
    else if (term_seen_q)                 rate_d = SBCC_CUR_MAINT;
    else                                  rate_d = SBCC_CUR_FAST;
  end

  logic [15:0] cur_d;
  always_comb begin
    unique case (rate_q)
      SBCC_CUR_ZERO:  cur_d = ZERO16;
      SBCC_CUR_PRE:   cur_d = cfg.pre_cur;
      SBCC_CUR_MAINT: cur_d = cfg.maint_cur;
      SBCC_CUR_FAST:  cur_d = cfg.fast_cur;
    endcase
  end

  logic [15:0] cur_q, volt_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= SBCC_CUR_ZERO;
      cur_q  <= ZERO16;
      volt_q <= ZERO16;
    end else begin
      rate_q <= rate_d;
      cur_q  <= cur_d;
      // voltage request reads zero while charging is barred
      volt_q <= any_fault ? ZERO16 : cfg.chg_volt;
    end
  end
  assign chg_cur_req  = cur_q;
  assign chg_volt_req = volt_q;
  assign rate         = rate_q;

  // ---------------------------------------------------------------
  // broadcast sequencer
  // ---------------------------------------------------------------
  wire bc_dis     = cfg.pack_cfg[BCAST_DIS_BIT];
  wire alarm_host = |batt_status[15:HOST_LO_BIT];
  wire alarm_chg  = |batt_status[15:CHG_LO_BIT];

  typedef enum logic [2:0] {
    SBCC_BC_IDLE, SBCC_BC_CUR, SBCC_BC_VOLT, SBCC_BC_AL_HOST,
    SBCC_BC_AL_CHG
  } sbcc_bc_state_t;

  sbcc_bc_state_t bc_q;
  logic           al_chg_q;
  wire            step = msg_ready;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bc_q     <= SBCC_BC_IDLE;
      al_chg_q <= 1'b0;
    end else begin
      unique case (bc_q)
        SBCC_BC_IDLE: if (tick_10s && !bc_dis) begin
          bc_q     <= SBCC_BC_CUR;
          al_chg_q <= alarm_chg;
        end
        SBCC_BC_CUR:  if (step) bc_q <= SBCC_BC_VOLT;
        SBCC_BC_VOLT: if (step) begin
          bc_q <= alarm_host ? SBCC_BC_AL_HOST : SBCC_BC_IDLE;
        end
        SBCC_BC_AL_HOST: if (step) begin
          bc_q <= al_chg_q ? SBCC_BC_AL_CHG : SBCC_BC_IDLE;
        end
        SBCC_BC_AL_CHG: if (step) bc_q <= SBCC_BC_IDLE;
        default: bc_q <= SBCC_BC_IDLE;
      endcase
    end
  end

  assign msg_valid = (bc_q != SBCC_BC_IDLE);
  always_comb begin
    msg = '{kind: SBCC_MSG_ALARM, dest: SBCC_ADDR_HOST, data: batt_status};
    unique case (bc_q)
      SBCC_BC_CUR:
        msg = '{kind: SBCC_MSG_CHG_CUR, dest: SBCC_ADDR_CHARGER, data: cur_q};
      SBCC_BC_VOLT:
        msg = '{kind: SBCC_MSG_CHG_VOLT, dest: SBCC_ADDR_CHARGER,
                data: volt_q};
      SBCC_BC_AL_CHG:
        msg = '{kind: SBCC_MSG_ALARM, dest: SBCC_ADDR_CHARGER,
                data: batt_status};
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_no_bcast_when_disabled;
    @(posedge clk_sys) disable iff (!rst_n)
    (bc_q == SBCC_BC_IDLE && bc_dis) |=> (bc_q == SBCC_BC_IDLE);
  endproperty
  a_no_bcast_when_disabled: assert property (p_no_bcast_when_disabled)
    else $error("broadcast started while disabled");

  property p_fault_kills_charge;
    @(posedge clk_sys) disable iff (!rst_n)
    any_fault |=> !chg_fet_on;
  endproperty
  a_fault_kills_charge: assert property (p_fault_kills_charge)
    else $error("charge FET on during fault");

  property p_oc_dsg;
    @(posedge clk_sys) disable iff (!rst_n)
    (oc_q && !cfg.nonremovable) |=> !dsg_fet_on;
  endproperty
  a_oc_dsg: assert property (p_oc_dsg)
    else $error("discharge FET on during overcurrent");

  property p_term_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    meas.terminate |=> (rate_q == SBCC_CUR_ZERO);
  endproperty
  a_term_zero: assert property (p_term_zero)
    else $error("rate not zero at termination");

  property p_cur_match;
    @(posedge clk_sys) disable iff (!rst_n)
    (rate_q == SBCC_CUR_FAST) |=> (chg_cur_req == $past(cfg.fast_cur));
  endproperty
  a_cur_match: assert property (p_cur_match)
    else $error("current request not fast rate");

  property p_pre_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    (pre_q && !any_fault && !meas.terminate) |-> (rate_d == SBCC_CUR_PRE);
  endproperty
  a_pre_latch: assert property (p_pre_latch)
    else $error("precharge latch ignored");

  property p_cold_pre;
    @(posedge clk_sys) disable iff (!rst_n)
    (!fast_ok_t && !any_fault && !meas.terminate) |->
      (rate_d == SBCC_CUR_PRE);
  endproperty
  a_cold_pre: assert property (p_cold_pre)
    else $error("fast rate below temperature hysteresis");

  property p_alarm_chg;
    @(posedge clk_sys) disable iff (!rst_n)
    (bc_q == SBCC_BC_AL_HOST && al_chg_q && step) |=>
      (bc_q == SBCC_BC_AL_CHG);
  endproperty
  a_alarm_chg: assert property (p_alarm_chg)
    else $error("charger alarm skipped");

endmodule : sbcc_charge_ctrl
`default_nettype wire

// [verif/sbcc_msg_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module sbcc_msg_sink
  import sbcc_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           slow,
  input  wire logic           msg_valid,
  input  wire sbcc_msg_word_t msg,
  output logic                msg_ready
);
  sbcc_msg_word_t got[$];
  logic [1:0]     wait_q;
  // slow sink holds every word off for three cycles
  assign msg_ready = msg_valid && (!slow || wait_q == 2'h3);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'h0;
    end else if (msg_valid && !msg_ready) begin
      wait_q <= wait_q + 2'h1;
    end else if (msg_valid) begin
      wait_q <= 2'h0;
      got.push_back(msg);
    end
  end
endmodule : sbcc_msg_sink
`default_nettype wire

// [verif/sbcc_charge_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sbcc_charge_ctrl_tb
  import sbcc_pkg::*;
;
  logic           clk_sys, nrst, slow, msg_valid, msg_ready;
  logic           chg_fet_on, dsg_fet_on;
  logic [15:0]    batt_status, chg_cur_req, chg_volt_req;
  logic [4:0]     fault_flags;
  sbcc_cfg_t      cfg;
  sbcc_meas_t     meas;
  sbcc_msg_word_t msg;
  sbcc_rate_t     rate;
  int             fails, tests_run;

  sbcc_charge_ctrl #(.SAMPLE_CYCLES(10), .BCAST_TICKS(4)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .meas(meas),
    .batt_status(batt_status), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg(msg), .chg_cur_req(chg_cur_req),
    .chg_volt_req(chg_volt_req), .rate(rate), .chg_fet_on(chg_fet_on),
    .dsg_fet_on(dsg_fet_on), .fault_flags(fault_flags));
  sbcc_msg_sink sink (.clk_sys(clk_sys), .rst_n(nrst), .slow(slow),
    .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready));

  // ----------------
  // helpers
  // ----------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic smp(int n);
    repeat (n * 10) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : smp
  task automatic rt(sbcc_rate_t r, logic [15:0] cur);
    chk("rate", 16'(r), 16'(rate));
    chk("cur_req", cur, chg_cur_req);
  endtask : rt
  task automatic collect(int n);
    int k;
    @(negedge clk_sys);
    while (msg_valid === 1'b1) @(negedge clk_sys);
    sink.got.delete();
    k = 0;
    while (sink.got.size() < n && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    chk("count", 16'(n), 16'(sink.got.size()));
  endtask : collect
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // ----------------
  // scenarios
  // ----------------
  task automatic t_bcast();
    int k;
    collect(2);
    chk("k0", 16'(SBCC_MSG_CHG_CUR), 16'(sink.got[0].kind));
    chk("d0", cfg.fast_cur, sink.got[0].data);
    chk("k1", 16'(SBCC_MSG_CHG_VOLT), 16'(sink.got[1].kind));
    chk("d1", cfg.chg_volt, sink.got[1].data);
    chk("dst", 16'(SBCC_ADDR_CHARGER), 16'(sink.got[1].dest));
    chk("vreq", cfg.chg_volt, chg_volt_req);
    rt(SBCC_CUR_FAST, cfg.fast_cur);
    while (msg_valid !== 1'b1) @(negedge clk_sys);
    k = 0;
    while (msg_valid === 1'b1) begin
      @(negedge clk_sys);
      k++;
    end
    while (msg_valid !== 1'b1 && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    chk("period", 16'h0028, 16'(k));
  endtask : t_bcast
  task automatic t_alarm();
    @(posedge clk_sys);
    batt_status <= 16'h1000;
    slow        <= 1'b1;
    smp(5);
    collect(4);
    chk("a2", 16'(SBCC_MSG_ALARM), 16'(sink.got[2].kind));
    chk("a2d", 16'(SBCC_ADDR_HOST), 16'(sink.got[2].dest));
    chk("a3d", 16'(SBCC_ADDR_CHARGER), 16'(sink.got[3].dest));
    collect(4);
    chk("rep", 16'(SBCC_MSG_ALARM), 16'(sink.got[3].kind));
    @(posedge clk_sys);
    batt_status <= 16'h0100;
    smp(5);
    collect(4);
    chk("h2", 16'(SBCC_ADDR_HOST), 16'(sink.got[2].dest));
    chk("h3", 16'(SBCC_MSG_CHG_CUR), 16'(sink.got[3].kind));
    @(posedge clk_sys);
    batt_status <= 16'h0000;
    slow        <= 1'b0;
    smp(5);
    collect(3);
    chk("stop", 16'(SBCC_MSG_CHG_CUR), 16'(sink.got[2].kind));
  endtask : t_alarm
  task automatic t_disable();
    @(posedge clk_sys);
    cfg.pack_cfg[2] <= 1'b1;
    batt_status     <= 16'h8000;
    smp(5);
    sink.got.delete();
    smp(10);
    chk("quiet", 16'h0000, 16'(sink.got.size()));
    @(posedge clk_sys);
    cfg.pack_cfg[2] <= 1'b0;
    batt_status     <= 16'h0000;
    smp(5);
  endtask : t_disable
  task automatic t_pre();
    @(posedge clk_sys);
    meas.cell_low <= 1'b1;
    smp(2);
    rt(SBCC_CUR_PRE, cfg.pre_cur);
    @(posedge clk_sys);
    meas.cell_low               <= 1'b0;
    meas.end_of_discharge_level <= 1'b1;
    smp(2);
    rt(SBCC_CUR_PRE, cfg.pre_cur);
    @(posedge clk_sys);
    meas.end_of_discharge_level <= 1'b0;
    meas.temp                   <= 16'h0032;
    smp(2);
    rt(SBCC_CUR_PRE, cfg.pre_cur);
    @(posedge clk_sys);
    meas.temp <= 16'h0081;
    smp(2);
    rt(SBCC_CUR_PRE, cfg.pre_cur);
    @(posedge clk_sys);
    meas.temp <= 16'h0082;
    smp(2);
    rt(SBCC_CUR_FAST, cfg.fast_cur);
    @(posedge clk_sys);
    cfg.pre_temp <= 16'h00c8;
    meas.temp    <= 16'h009c;
    smp(2);
    rt(SBCC_CUR_PRE, cfg.pre_cur);
    @(posedge clk_sys);
    meas.temp <= 16'h009d;
    smp(2);
    rt(SBCC_CUR_FAST, cfg.fast_cur);
    @(posedge clk_sys);
    cfg.pre_temp <= 16'h0064;
    meas.temp    <= 16'h00fa;
  endtask : t_pre
  task automatic t_faults();
    @(posedge clk_sys);
    meas.chg_cur <= 16'h0fa0;
    smp(1);
    chk("oc_early", 16'h0000, 16'(fault_flags[0]));
    smp(4);
    chk("oc", 16'h0001, 16'(fault_flags[0]));
    chk("oc_dsg", 16'h0000, 16'(dsg_fet_on));
    chk("oc_chg", 16'h0000, 16'(chg_fet_on));
    @(posedge clk_sys);
    meas.chg_cur      <= 16'h01f4;
    meas.pack_removed <= 1'b1;
    smp(2);
    chk("oc_clr", 16'h0000, 16'(fault_flags[0]));
    @(posedge clk_sys);
    meas.pack_removed <= 1'b0;
    meas.pack_volt    <= 16'h4650;
    smp(3);
    chk("ov", 16'h0001, 16'(fault_flags[1]));
    chk("ov_chg", 16'h0000, 16'(chg_fet_on));
    @(posedge clk_sys);
    meas.pack_volt    <= 16'h3e80;
    meas.pack_removed <= 1'b1;
    smp(2);
    chk("ov_clr", 16'h0000, 16'(fault_flags[1]));
    @(posedge clk_sys);
    meas.pack_removed <= 1'b0;
    meas.temp         <= 16'h01f4;
    smp(3);
    chk("ot", 16'h0001, 16'(fault_flags[2]));
    chk("ot_fet", 16'h0000, 16'({chg_fet_on, dsg_fet_on}));
    @(posedge clk_sys);
    meas.temp <= 16'h0190;
    smp(3);
    chk("ot_clr", 16'h0000, 16'(fault_flags[2]));
    @(posedge clk_sys);
    meas.temp <= 16'h000a;
    smp(3);
    chk("ut", 16'h0001, 16'(fault_flags[3]));
    @(posedge clk_sys);
    meas.temp <= 16'h0015;
    smp(3);
    chk("ut_clr", 16'h0000, 16'(fault_flags[3]));
    @(posedge clk_sys);
    meas.temp <= 16'h00fa;
  endtask : t_faults
  task automatic t_pulse();
    smp(4);
    chk("p_on", 16'h0001, 16'(chg_fet_on));
    @(posedge clk_sys);
    meas.cell_max <= 16'h10fe;
    smp(2);
    chk("p_max", 16'h0000, 16'(chg_fet_on));
    @(posedge clk_sys);
    meas.cell_max <= 16'h0fa0;
    smp(4);
    chk("p_back", 16'h0001, 16'(chg_fet_on));
    @(posedge clk_sys);
    cfg.max_chg_time <= 16'h0001;
    smp(2);
    chk("tm", 16'h0001, 16'(fault_flags[4]));
    chk("tm_chg", 16'h0000, 16'(chg_fet_on));
    @(posedge clk_sys);
    cfg.max_chg_time <= 16'hffff;
    meas.discharging <= 1'b1;
    smp(2);
    chk("tm_clr", 16'h0000, 16'(fault_flags[4]));
    @(posedge clk_sys);
    meas.discharging <= 1'b0;
    smp(4);
  endtask : t_pulse
  task automatic t_term();
    @(posedge clk_sys);
    meas.terminate <= 1'b1;
    smp(2);
    rt(SBCC_CUR_ZERO, 16'h0000);
    @(posedge clk_sys);
    meas.terminate <= 1'b0;
    smp(2);
    rt(SBCC_CUR_MAINT, cfg.maint_cur);
  endtask : t_term

  // ----------------
  // run
  // ----------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end
  initial begin
    fails       = 0;
    tests_run   = 0;
    nrst        = 1'b0;
    slow        = 1'b0;
    batt_status = 16'h0000;
    cfg  = '{16'h41a0, 16'h03e8, 16'h1130, 16'h07d0, 16'h0064, 16'h00fa,
             16'h0bb8, 16'h0064, 16'h0014, 16'h0014, 16'h01c2, 16'h0190,
             16'h0bb8, 8'h02, 16'h0032, 8'h04, 16'hffff, 16'h1004,
             16'h1068, 16'h10cc, 8'h02, 8'h04, 8'h00, 1'b0, 1'b1};
    meas = '{16'h3e80, 16'h0fa0, 16'h00fa, 16'h01f4, 16'h01f4,
             1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("rst", 16'h0000, 16'({chg_fet_on, dsg_fet_on, msg_valid}));
    @(posedge clk_sys);
    nrst <= 1'b1;
    smp(1);
    chk("dsg", 16'h0001, 16'(dsg_fet_on));
    t_bcast();
    t_alarm();
    t_disable();
    t_pre();
    t_faults();
    t_pulse();
    t_term();
    conclude();
  end
endmodule : sbcc_charge_ctrl_tb
`default_nettype wire
